// [dv/phy_mode_and_led_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_mode_and_led_select_tb
   import pmls_pkg::*;
;
   logic clk_sys_i = 1'b0, rstn, psel, pen, pwr, r0s, r0d, aen, sfd, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [5:0]  st;
   logic [1:0]  res;
   logic [3:0]  strb;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, dn, asp, adx, mode, spd, fdx, la, lb;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   pmls_top i_dut (.clk_sys_i(clk_sys_i), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .phy_reg0_speed_i(r0s), .phy_reg0_duplex_i(r0d), .phy_autoneg_enable_i(aen),
      .nego_done_i(dn), .nego_speed_i(asp), .nego_duplex_i(adx),
      .switched_full_duplex_i(sfd), .link10_status_i(st[0]), .full_duplex_status_i(st[1]),
      .activity_status_i(st[2]), .link100_status_i(st[3]), .receive_status_i(st[4]),
      .transmit_status_i(st[5]), .phy_autoneg_mode_o(mode), .phy_speed_100_o(spd),
      .phy_full_duplex_o(fdx), .indicator_a_out_o(la), .indicator_b_out_o(lb));
   pmls_phy_model i_phy (.clk_sys_i(clk_sys_i), .autoneg_mode_i(mode), .result_i(res),
      .nego_done_o(dn), .nego_speed_o(asp), .nego_duplex_o(adx));
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys_i);
      pen <= 1'b1;
      @(posedge clk_sys_i iff (pready === 1'b1));
      rd = prdata;
      er = pslverr;
      {psel, pen} <= 2'b00;
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask
   function automatic logic lexp(input logic [2:0] c, input logic [5:0] s);
      case (c)
         3'h0: return s[3] | s[0];
         3'h1: return 1'b0;
         default: return s[c - 3'h2];
      endcase
   endfunction
   task automatic t_reset;
      @(posedge clk_sys_i);
      st <= 6'h08;
      hold(6);
      chk(la, 1'b1);
      chk(lb, 1'b1);
   endtask
   task automatic t_manual;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         {r0s, r0d, aen} <= {~i[1], ~i[0], i[0]};
         sfd <= i[0];
         apb(1'b1, PMLS_ADDR_LINK_CTRL, {18'h0, i[1], i[0], 12'h0});
         hold(4);
         chk(spd, i[1]);
         chk(fdx, i[0]);
         chk(mode, 1'b0);
         apb(1'b0, PMLS_ADDR_PHY_STATUS, 32'h0);
         chk(rd, {23'h000000, i[0], 6'h08, i[1], i[0]});
      end
   endtask
   task automatic t_mac_autoneg_select;
      @(posedge clk_sys_i);
      {r0s, r0d, aen} <= 3'b100;
      apb(1'b1, PMLS_ADDR_LINK_CTRL, 32'h0000_1800);
      hold(4);
      chk({mode, spd, fdx}, 3'b010);
      @(posedge clk_sys_i);
      {r0s, r0d, aen, res} <= 5'b00111;
      hold(2);
      chk({spd, fdx}, 2'b10);
      hold(10);
      chk(mode, 1'b1);
      chk({spd, fdx}, 2'b11);
      apb(1'b1, PMLS_ADDR_LINK_CTRL, 32'h0);
   endtask
   task automatic t_led;
      logic [2:0] c;
      for (int k = 0; k < 16; k++) begin
         c = k[3:1];
         @(posedge clk_sys_i);
         st <= k[0] ? 6'h29 : 6'h16;
         apb(1'b1, PMLS_ADDR_LINK_CTRL, {24'h0, c, ~c, 2'h0});
         hold(6);
         chk(la, lexp(c, st));
         chk(lb, lexp(~c, st));
      end
   endtask
   task automatic t_err;
      apb(1'b1, PMLS_ADDR_LINK_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, PMLS_ADDR_LINK_CTRL, 32'h0);
      chk(er, 1'b0);
      chk(rd, {16'h0000, PMLS_LINK_CTRL_MASK});
      strb <= 4'h2;
      apb(1'b1, PMLS_ADDR_LINK_CTRL, 32'h0);
      strb <= 4'hF;
      apb(1'b0, PMLS_ADDR_LINK_CTRL, 32'h0);
      chk(rd, 32'h0000_00FC);
      apb(1'b0, 12'h004, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      apb(1'b1, PMLS_ADDR_PHY_STATUS, 32'h0);
      chk(er, 1'b1);
   endtask
   task automatic t_rst2;
      @(posedge clk_sys_i);
      rstn <= 1'b0;
      @(negedge clk_sys_i);
      chk({la, lb, mode, spd, fdx, pready}, 6'h00);
      @(posedge clk_sys_i);
      rstn <= 1'b1;
      apb(1'b0, PMLS_ADDR_LINK_CTRL, 32'h0);
      chk(rd, {16'h0000, PMLS_LINK_CTRL_RESET});
   endtask
   initial begin
      {rstn, psel, pen, pwr, r0s, r0d, aen, sfd, paddr, pwdata, st, res} <= '0;
      strb <= 4'hF;
      repeat (2) @(posedge clk_sys_i);
      rstn <= 1'b1;
      t_reset;
      t_manual;
      t_mac_autoneg_select;
      t_led;
      t_err;
      t_rst2;
      test_done;
   end
endmodule
`default_nettype wire

// [dv/pmls_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmls_phy_model (
   input  wire logic       clk_sys_i,
   input  wire logic       autoneg_mode_i,
   input  wire logic [1:0] result_i,
   output logic            nego_done_o,
   output logic            nego_speed_o,
   output logic            nego_duplex_o
);
   logic [2:0] cnt_q;
   // negotiation settles 4 cycles after entering autoneg mode
   always_ff @(posedge clk_sys_i) begin
      cnt_q <= !autoneg_mode_i ? 3'h0 : (cnt_q == 3'h4) ? cnt_q : cnt_q + 3'h1;
   end
   assign nego_done_o = (cnt_q == 3'h4);
   // result not valid before done: show its inverse
   assign nego_speed_o  = nego_done_o ? result_i[1] : ~result_i[1];
   assign nego_duplex_o = nego_done_o ? result_i[0] : ~result_i[0];
endmodule
`default_nettype wire

// [verilog/pmls_led_mux.sv]
`timescale 1ns/1ps
`default_nettype none
// one indicator output: selects a status source, registered
module pmls_led_mux
   import pmls_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic [2:0] sel_i,
   input  wire logic [5:0] status_i,
   output logic            led_o
);
   logic led_d;
   logic led_q;

   always_comb begin
      case (sel_i)
         PMLS_SEL_ANY_LINK: led_d = status_i[3] | status_i[0];
         PMLS_SEL_RESERVED: led_d = 1'b0;
         PMLS_SEL_LINK10:   led_d = status_i[0];
         PMLS_SEL_FDX:      led_d = status_i[1];
         PMLS_SEL_ACTIVITY: led_d = status_i[2];
         PMLS_SEL_LINK100:  led_d = status_i[3];
         PMLS_SEL_RECEIVE:  led_d = status_i[4];
         PMLS_SEL_TRANSMIT: led_d = status_i[5];
         default:           led_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         led_q <= 1'b0;
      end else begin
         led_q <= led_d;
      end
   end

   assign led_o = led_q;
endmodule
`default_nettype wire

// [verilog/pmls_pkg.sv]
`default_nettype none
package pmls_pkg;
   // register map: byte address is four times the word index
   localparam logic [7:0]  PMLS_IDX_LINK_CTRL   = 8'h0A;
   localparam logic [11:0] PMLS_ADDR_LINK_CTRL  = {2'h0, PMLS_IDX_LINK_CTRL, 2'h0};
   localparam logic [11:0] PMLS_ADDR_PHY_STATUS = 12'h030;
   // field positions inside phy_link_control
   localparam int PMLS_BIT_SPEED     = 13;
   localparam int PMLS_BIT_DUPLEX    = 12;
   localparam int PMLS_BIT_AUTONEG   = 11;
   localparam int PMLS_LSB_SEL_A     = 5;
   localparam int PMLS_LSB_SEL_B     = 2;
   localparam logic [15:0] PMLS_LINK_CTRL_MASK  = 16'h38FC;
   localparam logic [15:0] PMLS_LINK_CTRL_RESET = 16'h0000;
   // indicator source codes
   localparam logic [2:0] PMLS_SEL_ANY_LINK = 3'h0;
   localparam logic [2:0] PMLS_SEL_RESERVED = 3'h1;
   localparam logic [2:0] PMLS_SEL_LINK10   = 3'h2;
   localparam logic [2:0] PMLS_SEL_FDX      = 3'h3;
   localparam logic [2:0] PMLS_SEL_ACTIVITY = 3'h4;
   localparam logic [2:0] PMLS_SEL_LINK100  = 3'h5;
   localparam logic [2:0] PMLS_SEL_RECEIVE  = 3'h6;
   localparam logic [2:0] PMLS_SEL_TRANSMIT = 3'h7;
endpackage
`default_nettype wire

// [verilog/pmls_top.sv]
// Overview of operation
// - With the MAC autoneg select clear, duplex_select sets PHY duplex (1 full, 0 half), overriding PHY reg 0.
// - With the MAC autoneg select set, duplex_select is ignored; duplex comes from negotiation or PHY reg 0.
// - The PHY autonegotiates only when both MAC select and PHY enable are set, else it is manual.
// - A three-bit selector picks the source of indicator A, default OR of both link states.
// - An independent three-bit selector with the same codes and default picks indicator B.
// - With the MAC autoneg select clear, the speed bit sets PHY speed (1 100M, 0 10M), overriding PHY reg 0.
`timescale 1ns/1ps
`default_nettype none
module pmls_top
   import pmls_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        phy_reg0_speed_i,
   input  wire logic        phy_reg0_duplex_i,
   input  wire logic        phy_autoneg_enable_i,
   input  wire logic        nego_done_i,
   input  wire logic        nego_speed_i,
   input  wire logic        nego_duplex_i,
   input  wire logic        switched_full_duplex_i,
   input  wire logic        link10_status_i,
   input  wire logic        full_duplex_status_i,
   input  wire logic        activity_status_i,
   input  wire logic        link100_status_i,
   input  wire logic        receive_status_i,
   input  wire logic        transmit_status_i,
   output logic             phy_autoneg_mode_o,
   output logic             phy_speed_100_o,
   output logic             phy_full_duplex_o,
   output logic             indicator_a_out_o,
   output logic             indicator_b_out_o
);
   logic [15:0] ctrl_d;
   logic [15:0] ctrl_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic        ready_d;
   logic        ready_q;
   logic        err_d;
   logic        err_q;
   logic [5:0]  stat_meta_q;
   logic [5:0]  stat_q;
   logic [5:0]  stat_raw;
   logic        mode_d;
   logic        mode_q;
   logic        spd_d;
   logic        spd_q;
   logic        dpx_d;
   logic        dpx_q;
   logic        acc;
   logic        hit_ctrl;
   logic        hit_stat;

   assign stat_raw = {transmit_status_i, receive_status_i, link100_status_i,
                      activity_status_i, full_duplex_status_i, link10_status_i};

   // status pins come from the PHY, synchronised
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stat_meta_q <= 6'h00;
         stat_q      <= 6'h00;
      end else begin
         stat_meta_q <= stat_raw;
         stat_q      <= stat_meta_q;
      end
   end

   // apb slave, one wait state, registered answer
   assign acc      = psel_i & penable_i & ~ready_q;
   assign hit_ctrl = (paddr_i == PMLS_ADDR_LINK_CTRL);
   assign hit_stat = (paddr_i == PMLS_ADDR_PHY_STATUS);

   always_comb begin
      ctrl_d  = ctrl_q;
      rdata_d = 32'h0000_0000;
      ready_d = acc;
      err_d   = acc & ~(hit_ctrl | (hit_stat & ~pwrite_i));
      if (acc && pwrite_i && hit_ctrl) begin
         if (pstrb_i[0]) begin
            ctrl_d[7:0] = pwdata_i[7:0] & PMLS_LINK_CTRL_MASK[7:0];
         end
         if (pstrb_i[1]) begin
            ctrl_d[15:8] = pwdata_i[15:8] & PMLS_LINK_CTRL_MASK[15:8];
         end
      end
      if (acc && !pwrite_i && hit_ctrl) begin
         rdata_d = {16'h0000, ctrl_q};
      end
      if (acc && !pwrite_i && hit_stat) begin
         rdata_d = {23'h000000, switched_full_duplex_i, stat_q, spd_q, dpx_q};
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q  <= PMLS_LINK_CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q   <= err_d;
      end
   end

   assign prdata_o  = rdata_q;
   assign pready_o  = ready_q;
   assign pslverr_o = err_q;

   // phy mode resolution
   always_comb begin
      mode_d = ctrl_q[PMLS_BIT_AUTONEG] & phy_autoneg_enable_i;
      if (!ctrl_q[PMLS_BIT_AUTONEG]) begin
         spd_d = ctrl_q[PMLS_BIT_SPEED];
         dpx_d = ctrl_q[PMLS_BIT_DUPLEX];
      end else if (!phy_autoneg_enable_i) begin
         spd_d = phy_reg0_speed_i;
         dpx_d = phy_reg0_duplex_i;
      end else if (nego_done_i) begin
         spd_d = nego_speed_i;
         dpx_d = nego_duplex_i;
      end else begin
         spd_d = spd_q;
         dpx_d = dpx_q;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= 1'b0;
         spd_q  <= 1'b0;
         dpx_q  <= 1'b0;
      end else begin
         mode_q <= mode_d;
         spd_q  <= spd_d;
         dpx_q  <= dpx_d;
      end
   end

   assign phy_autoneg_mode_o = mode_q;
   assign phy_speed_100_o    = spd_q;
   assign phy_full_duplex_o  = dpx_q;

   pmls_led_mux u_led_a (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .sel_i     (ctrl_q[PMLS_LSB_SEL_A +: 3]),
      .status_i  (stat_q),
      .led_o     (indicator_a_out_o)
   );

   pmls_led_mux u_led_b (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .sel_i     (ctrl_q[PMLS_LSB_SEL_B +: 3]),
      .status_i  (stat_q),
      .led_o     (indicator_b_out_o)
   );

   AST_MANUAL_DUPLEX: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !ctrl_q[PMLS_BIT_AUTONEG] |=> phy_full_duplex_o == $past(ctrl_q[PMLS_BIT_DUPLEX]))
      else $error("manual duplex not applied");
   AST_AUTONEG_IGNORES: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_BIT_AUTONEG] && !phy_autoneg_enable_i
      |=> phy_full_duplex_o == $past(phy_reg0_duplex_i))
      else $error("duplex not from phy reg 0");
   AST_AUTONEG_SPEED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_BIT_AUTONEG] && !phy_autoneg_enable_i
      |=> phy_speed_100_o == $past(phy_reg0_speed_i))
      else $error("speed not from phy reg 0");
   AST_NEGO_RESULT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_BIT_AUTONEG] && phy_autoneg_enable_i && nego_done_i
      |=> {phy_speed_100_o, phy_full_duplex_o} == $past({nego_speed_i, nego_duplex_i}))
      else $error("negotiation result not applied");
   AST_AUTONEG_MODE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ##1 phy_autoneg_mode_o == $past(ctrl_q[PMLS_BIT_AUTONEG] & phy_autoneg_enable_i))
      else $error("autoneg mode wrong");
   AST_MANUAL_MODE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !(ctrl_q[PMLS_BIT_AUTONEG] && phy_autoneg_enable_i) |=> !phy_autoneg_mode_o)
      else $error("autoneg mode without both bits");
   AST_MANUAL_SPEED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !ctrl_q[PMLS_BIT_AUTONEG] |=> phy_speed_100_o == $past(ctrl_q[PMLS_BIT_SPEED]))
      else $error("manual speed not applied");
   AST_LED_A_TX: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_LSB_SEL_A +: 3] == PMLS_SEL_TRANSMIT && transmit_status_i
      ##0 ctrl_q[PMLS_LSB_SEL_A +: 3] == PMLS_SEL_TRANSMIT [*4] |-> indicator_a_out_o)
      else $error("indicator a misses transmit");
   AST_LED_A_LINK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_LSB_SEL_A +: 3] == PMLS_SEL_ANY_LINK && $past(stat_q[3] | stat_q[0])
      && $past(ctrl_q[PMLS_LSB_SEL_A +: 3]) == PMLS_SEL_ANY_LINK |-> indicator_a_out_o)
      else $error("indicator a misses link");
   AST_LED_B_LINK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_LSB_SEL_B +: 3] == PMLS_SEL_ANY_LINK && $past(stat_q[3] | stat_q[0])
      && $past(ctrl_q[PMLS_LSB_SEL_B +: 3]) == PMLS_SEL_ANY_LINK |-> indicator_b_out_o)
      else $error("indicator b misses link");
   AST_LED_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_LSB_SEL_A +: 3] == PMLS_SEL_RESERVED |=> !indicator_a_out_o)
      else $error("reserved code drives indicator");
   AST_LED_B_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ctrl_q[PMLS_LSB_SEL_B +: 3] == PMLS_SEL_RESERVED |=> !indicator_b_out_o)
      else $error("reserved code drives indicator b");
   AST_APB_ONE_CYCLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
      else $error("apb answer not one cycle");
   AST_APB_REFUSED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      psel_i && penable_i && !pready_o && !hit_ctrl && !hit_stat |=> pslverr_o)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire
